// [sensor_identity_register_bank.sv]
// Identity register bank with the periodic conversion timer.
//
// How it works
// R1: Address 09h returns serial bits 47:32, read-only.
// R2: Address 0Ah returns serial bits 31:16.
// R3: Address 0Bh returns serial bits 15:0.
// R4: Address 0Ch gives revision and part code.
// R5: Conversions periodic, 1 s default, 5.5ms-2s.
// R6: Fast register reads never disturb conversion timing.
// R7: Identity reads have no side effects, repeatable.
`timescale 1ns/10ps
module sensor_identity_register_bank
    import sensor_id_pkg::*;
#(
    // Arbitrary neutral identity values, not those of any real part.
    parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0000,
    parameter logic [3:0]  REVISION      = 4'h3,
    parameter logic [11:0] PART_CODE     = 12'h5a7,
    parameter int          STEP_CYC      = STEP_CYCLES
)
(
    input  wire logic                clk_i,
    input  wire logic                srst_i,
    input  wire reg_req_t            reg_req_i,
    output reg_rsp_t                 reg_rsp_o,
    input  wire logic                period_wr_i,
    input  wire logic [PERIOD_W-1:0] period_i,
    output logic      [PERIOD_W-1:0] period_o,
    output logic                     conv_start_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // A zero step would leave the prescaler without a terminal count.
    if (STEP_CYC < 1)
    begin : g_bad_step
        $error("STEP_CYC must be at least one cycle");
    end

    // The timer fires at period minus one, so zero can never be a period.
    if (PERIOD_MIN == '0)
    begin : g_bad_min
        $error("PERIOD_MIN must be at least one step");
    end

    // Reset must land on a period that a write could also have set.
    if (PERIOD_DEFAULT < PERIOD_MIN || PERIOD_DEFAULT > PERIOD_MAX)
    begin : g_bad_default
        $error("PERIOD_DEFAULT must lie between PERIOD_MIN and PERIOD_MAX");
    end

    // The identity word packs revision above part code with nothing spare.
    if (REV_W + PART_CODE_W != WORD_W)
    begin : g_bad_ident_w
        $error("Revision and part code must fill one word");
    end

    if (REV_LSB != PART_LSB + PART_CODE_W)
    begin : g_bad_ident_pos
        $error("Revision must sit directly above the part code");
    end

    // The serial number is read as three whole words, high word first.
    if (SERIAL_W != 3 * WORD_W)
    begin : g_bad_serial_w
        $error("The serial number must span three words");
    end

    if (SERIAL_MID_LSB != SERIAL_LO_LSB + WORD_W
        || SERIAL_HI_LSB != SERIAL_MID_LSB + WORD_W)
    begin : g_bad_serial_pos
        $error("Serial words must follow each other without gaps");
    end

    // The carriers must agree with the widths that the decode assumes.
    if ($bits(reg_req_t) != 2 + ADDR_W + WORD_W || $bits(reg_rsp_t) != 1 + WORD_W)
    begin : g_bad_carrier
        $error("Register carriers must match the address and word widths");
    end

    localparam int STEP_W = $clog2(STEP_CYC + 1);

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // Writes are accepted but discarded; the words are factory values.
    // Valid is registered beside the store's data register, so both change on one edge.
    // Unmapped addresses answer zero, so a stray read never leaves a host waiting.
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [15:0] rdata;

    id_word_store #(
        .SERIAL_NUMBER (SERIAL_NUMBER),
        .REVISION      (REVISION),
        .PART_CODE     (PART_CODE)
    ) u_store (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .rd_i    (reg_req_i.rd),
        .addr_i  (reg_req_i.addr),
        .rdata_o (rdata)
    );

    always_comb
    begin
        rvalid_nxt = reg_req_i.rd; // R7
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rvalid_r <= 1'b0;
        else
            rvalid_r <= rvalid_nxt;
    end

    assign reg_rsp_o.valid = rvalid_r;
    assign reg_rsp_o.data  = rdata;

    // ------------------------------------------------------------------
    // Conversion period setting
    // ------------------------------------------------------------------
    // Out-of-range requests are clamped so the timer never stalls or races.
    // Clamping rather than refusing means a host never sees a write ignored.
    logic [PERIOD_W-1:0] period_r;
    logic [PERIOD_W-1:0] period_nxt;

    always_comb
    begin
        period_nxt = period_r;
        if (period_wr_i)
        begin
            if (period_i < PERIOD_MIN)
                period_nxt = PERIOD_MIN; // R5
            else if (period_i > PERIOD_MAX)
                period_nxt = PERIOD_MAX; // R5
            else
                period_nxt = period_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            period_r <= PERIOD_DEFAULT; // R5
        else
            period_r <= period_nxt;
    end

    assign period_o = period_r;

    // ------------------------------------------------------------------
    // Step prescaler
    // ------------------------------------------------------------------
    // The timer reads nothing from the register port, so reads at any rate
    // cannot shift or drop a conversion.
    // A step is a fixed count of clocks, so another clock rate needs another STEP_CYC.
    logic [STEP_W-1:0]   step_cnt_r;
    logic [STEP_W-1:0]   step_cnt_nxt;
    logic                step_end;

    always_comb
    begin
        step_end     = (step_cnt_r >= STEP_W'(STEP_CYC - 1));
        step_cnt_nxt = step_cnt_r + STEP_W'(1);
        if (step_end)
            step_cnt_nxt = '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            step_cnt_r <= '0;
        else
            step_cnt_r <= step_cnt_nxt;
    end

    // ------------------------------------------------------------------
    // Conversion timer
    // ------------------------------------------------------------------
    // A period cut below the running count fires at the next step rather
    // than wrapping once through the whole counter range.
    logic [PERIOD_W-1:0] per_cnt_r;
    logic [PERIOD_W-1:0] per_cnt_nxt;
    logic                start_r;
    logic                start_nxt;

    always_comb
    begin
        per_cnt_nxt = per_cnt_r;
        start_nxt   = 1'b0;
        if (step_end)
        begin
            if (per_cnt_r >= period_r - PERIOD_W'(1))
            begin
                per_cnt_nxt = '0;
                start_nxt   = 1'b1; // R5 R6
            end
            else
                per_cnt_nxt = per_cnt_r + PERIOD_W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            per_cnt_r <= '0;
            start_r   <= 1'b0;
        end
        else
        begin
            per_cnt_r <= per_cnt_nxt;
            start_r   <= start_nxt;
        end
    end

    assign conv_start_o = start_r;

endmodule

// [sensor_id_pkg.sv]
// Package with the register map, field layout and timing constants of the identity bank.
package sensor_id_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SERIAL_HIGH   = 8'h09;
    localparam logic [7:0] ADDR_SERIAL_MID    = 8'h0a;
    localparam logic [7:0] ADDR_SERIAL_LOW    = 8'h0b;
    localparam logic [7:0] ADDR_PART_IDENTITY = 8'h0c;

    localparam int         WORD_W       = 16;
    localparam int         ADDR_W       = 8;
    localparam int         SERIAL_W     = 48;
    localparam int         REV_W        = 4;
    localparam int         PART_CODE_W  = 12;
    localparam int         REV_LSB      = 12;
    localparam int         PART_LSB     = 0;
    localparam int         SERIAL_HI_LSB = 32;
    localparam int         SERIAL_MID_LSB = 16;
    localparam int         SERIAL_LO_LSB = 0;
    localparam logic [15:0] UNMAPPED_DATA = 16'h0000;

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          PERIOD_STEP_PS  = 500000000;
    localparam int          STEP_CYCLES     = PERIOD_STEP_PS / CLK_PERIOD_PS;
    localparam int          PERIOD_W        = 12;
    localparam logic [11:0] PERIOD_MIN      = 12'h00b;
    localparam logic [11:0] PERIOD_MAX      = 12'hfa0;
    localparam logic [11:0] PERIOD_DEFAULT  = 12'h7d0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [7:0]        addr;
        logic [15:0]       wdata;
    } reg_req_t;

    typedef struct packed {
        logic              valid;
        logic [15:0]       data;
    } reg_rsp_t;

endpackage

// [id_word_store.sv]
// Read-only store of the four identity words with a registered read port.
`timescale 1ns/10ps
module id_word_store
    import sensor_id_pkg::*;
#(
    // Arbitrary neutral identity values, not those of any real part.
    parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0000,
    parameter logic [3:0]  REVISION      = 4'h3,
    parameter logic [11:0] PART_CODE     = 12'h5a7
)
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  addr_i,
    output logic      [15:0] rdata_o
);

    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (rd_i)
        begin
            if (addr_i == ADDR_SERIAL_HIGH)
                rdata_nxt = SERIAL_NUMBER[SERIAL_HI_LSB +: WORD_W]; // R1
            else if (addr_i == ADDR_SERIAL_MID)
                rdata_nxt = SERIAL_NUMBER[SERIAL_MID_LSB +: WORD_W]; // R2
            else if (addr_i == ADDR_SERIAL_LOW)
                rdata_nxt = SERIAL_NUMBER[SERIAL_LO_LSB +: WORD_W]; // R3
            else if (addr_i == ADDR_PART_IDENTITY)
                rdata_nxt = {REVISION, PART_CODE}; // R4
            else
                rdata_nxt = UNMAPPED_DATA;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_r <= UNMAPPED_DATA;
        else
            rdata_r <= rdata_nxt;
    end

    assign rdata_o = rdata_r;

endmodule

// [sensor_identity_register_bank_asserts.sv]
// Port checker of the identity register bank.
`timescale 1ns/10ps
module sensor_identity_register_bank_asserts
    import sensor_id_pkg::*;
#(
    // Arbitrary neutral defaults; the bind hands in the design's values.
    parameter logic [47:0] SERIAL_NUMBER = 48'h0,
    parameter logic [3:0]  REVISION      = 4'h3,
    parameter logic [11:0] PART_CODE     = 12'h5a7,
    parameter int          STEP_CYC      = STEP_CYCLES
)
(
    input wire logic                clk_i,
    input wire logic                srst_i,
    input wire reg_req_t            reg_req_i,
    input wire reg_rsp_t            reg_rsp_o,
    input wire logic                period_wr_i,
    input wire logic [PERIOD_W-1:0] period_i,
    input wire logic [PERIOD_W-1:0] period_o,
    input wire logic                conv_start_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Intervals touched by reset or a period write are skipped, their length is mixed.
    logic [31:0] cnt_r, cnt_nxt;
    logic        chg_r, chg_nxt;
    always_comb
    begin
        cnt_nxt = conv_start_o ? 32'h1 : cnt_r + 32'h1;
        chg_nxt = period_wr_i | (chg_r & ~conv_start_o);
    end
    always_ff @(posedge clk_i)
    begin
        cnt_r <= srst_i ? 32'h0 : cnt_nxt;
        chg_r <= srst_i | chg_nxt;
    end
    sequence rd_at(logic [7:0] a);
        reg_req_i.rd && reg_req_i.addr == a;
    endsequence
    ser_high_a: assert property (rd_at(ADDR_SERIAL_HIGH) |=>
        reg_rsp_o.data == SERIAL_NUMBER[47:32]) else $error("bad high word");
    ser_mid_a: assert property (rd_at(ADDR_SERIAL_MID) |=>
        reg_rsp_o.data == SERIAL_NUMBER[31:16]) else $error("bad mid word");
    ser_low_a: assert property (rd_at(ADDR_SERIAL_LOW) |=>
        reg_rsp_o.data == SERIAL_NUMBER[15:0]) else $error("bad low word");
    ident_word_a: assert property (rd_at(ADDR_PART_IDENTITY) |=>
        reg_rsp_o.data == {REVISION, PART_CODE}) else $error("bad identity");
    rd_answer_a: assert property (reg_req_i.rd |=> reg_rsp_o.valid ##1
        reg_rsp_o.valid == $past(reg_req_i.rd)) else $error("bad valid");
    wr_ignored_a: assert property (reg_req_i.wr && !reg_req_i.rd |=>
        !reg_rsp_o.valid && $stable(reg_rsp_o.data)) else $error("write seen");
    period_load_a: assert property (period_wr_i |=> period_o == (
        $past(period_i) < PERIOD_MIN ? PERIOD_MIN :
        $past(period_i) > PERIOD_MAX ? PERIOD_MAX : $past(period_i)))
        else $error("bad period load");
    conv_gap_a: assert property (conv_start_o && !chg_r |->
        cnt_r == period_o * STEP_CYC) else $error("bad conversion gap");
endmodule

// [id_host_model.sv]
// Host model that reads and writes the identity bank.
`timescale 1ns/10ps
module id_host_model
    import sensor_id_pkg::*;
(
    input  wire logic     clk_i,
    output reg_req_t      req_o,
    input  wire reg_rsp_t rsp_i
);
    initial req_o = '0;
    // Reads may follow every cycle, faster than any conversion.
    task automatic rd(input logic [7:0] a, output reg_rsp_t r);
        req_o = {1'b1, 1'b0, a, 16'h0};
        @(negedge clk_i);
        r = rsp_i;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req_o = {1'b0, 1'b1, a, d};
        @(negedge clk_i);
    endtask
    task automatic idle();
        req_o = {2'b00, ~req_o.addr, ~req_o.wdata};
    endtask
endmodule

// [sensor_identity_register_bank_tb.sv]
// Self-checking testbench of the identity register bank.
`timescale 1ns/10ps
module sensor_identity_register_bank_tb
    import sensor_id_pkg::*;
;
    localparam logic [47:0] SER = 48'h3c5a_96e1_0f78;
    localparam int          STEP_SIM = 4;
    logic                clk_i = 0, srst_i = 1, period_wr_i = 0, conv_start_o;
    logic [PERIOD_W-1:0] period_i = '0, period_o;
    reg_req_t            reg_req_i;
    reg_rsp_t            reg_rsp_o, r;
    int                  miscompares = 0, n_checks = 0;
    sensor_identity_register_bank #(.SERIAL_NUMBER(SER), .STEP_CYC(STEP_SIM))
        u_sensor_identity_register_bank (.clk_i(clk_i), .srst_i(srst_i),
        .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o), .period_wr_i(period_wr_i),
        .period_i(period_i), .period_o(period_o), .conv_start_o(conv_start_o));
    id_host_model u_id_host_model (.clk_i(clk_i), .req_o(reg_req_i), .rsp_i(reg_rsp_o));
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        n_checks++;
        if (a !== e)
        begin
            miscompares++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic t_period();
        logic [11:0] pin [3] = '{12'h005, 12'hfff, 12'h00c};
        logic [11:0] pex [3] = '{PERIOD_MIN, PERIOD_MAX, 12'h00c};
        int n = 0;
        chk(16'(PERIOD_DEFAULT), 16'(period_o));
        chk(16'h0, 16'(conv_start_o));
        chk(16'h0, reg_rsp_o.data);
        chk(16'h0, 16'(reg_rsp_o.valid));
        for (int i = 0; i < 3; i++)
        begin
            period_i = pin[i];
            period_wr_i = 1'b1;
            @(negedge clk_i);
            period_wr_i = 1'b0;
            @(negedge clk_i);
            chk(16'(pex[i]), 16'(period_o));
        end
        while (conv_start_o !== 1'b1 && n < 300)
        begin
            @(negedge clk_i);
            n++;
        end
        for (n = 1; n < 300; n++)
        begin
            u_id_host_model.rd(ADDR_PART_IDENTITY, r);
            if (conv_start_o === 1'b1)
                break;
        end
        u_id_host_model.idle();
        chk(16'(pex[2]) * 16'(STEP_SIM), 16'(n));
    endtask
    task automatic t_ids();
        logic [7:0]  ad [5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
        logic [15:0] ex [5] = '{SER[47:32], SER[31:16], SER[15:0], 16'h35a7, 16'h0};
        for (int i = 0; i < 10; i++)
        begin
            u_id_host_model.rd(ad[i % 5], r);
            chk(ex[i % 5], r.data);
            chk(16'h1, 16'(r.valid));
        end
        u_id_host_model.wr(ADDR_SERIAL_HIGH, 16'hffff);
        chk(16'h0, 16'(reg_rsp_o.valid));
        u_id_host_model.rd(ADDR_SERIAL_HIGH, r);
        chk(SER[47:32], r.data);
        u_id_host_model.idle();
        @(negedge clk_i);
        chk(SER[47:32], reg_rsp_o.data);
        chk(16'h0, 16'(reg_rsp_o.valid));
    endtask
    task automatic test_done();
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        t_period();
        t_ids();
        test_done();
    end
    initial
    begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule
bind sensor_identity_register_bank sensor_identity_register_bank_asserts #(
    .SERIAL_NUMBER(SERIAL_NUMBER), .REVISION(REVISION),
    .PART_CODE(PART_CODE), .STEP_CYC(STEP_CYC))
    u_chk (.clk_i(clk_i), .srst_i(srst_i), .reg_req_i(reg_req_i),
    .reg_rsp_o(reg_rsp_o), .period_wr_i(period_wr_i), .period_i(period_i),
    .period_o(period_o), .conv_start_o(conv_start_o));
